// file: llq_params.svh
// Offsets, field positions, reset values and encodings of the load qualifier
`ifndef LLQ_PARAMS_SVH
`define LLQ_PARAMS_SVH
// Register addresses on the model-specific register port
`define LLQ_ADDR_OC_CFG    32'h0000_01a6
`define LLQ_ADDR_THRESH    32'h0000_03f6
// Field positions
`define LLQ_THR_MSB        15
`define LLQ_OC_REQ_LSB     0
`define LLQ_OC_RSP_LSB     8
`define LLQ_OC_RSVD_BIT    11
// Writable mask of the off-core config (bit 11 reserved)
`define LLQ_OC_WMASK       16'hf7ff
// Reset values
`define LLQ_THR_RST        16'h0003
`define LLQ_OC_RST         16'h0000
// Event code and unit mask that select off-core counting
`define LLQ_OC_EVT_CODE    8'hb7
`define LLQ_OC_UMASK       8'h01
// Data-source codes
`define LLQ_DS_UNK_MISS    4'h0
`define LLQ_DS_L1          4'h1
`define LLQ_DS_PENDING     4'h2
`define LLQ_DS_L2          4'h3
`define LLQ_DS_L3_NOSNP    4'h4
`define LLQ_DS_PEER_CLEAN  4'h5
`define LLQ_DS_PEER_MOD    4'h6
`define LLQ_DS_LAST_MODHIT 4'h7
`define LLQ_DS_FWD_LOCAL   4'h8
`define LLQ_DS_LMEM_SH     4'ha
`define LLQ_DS_RMEM_SH     4'hb
`define LLQ_DS_LMEM_EX     4'hc
`define LLQ_DS_RMEM_EX     4'hd
`define LLQ_DS_IO          4'he
`define LLQ_DS_UC          4'hf
// Latency counter ceiling
`define LLQ_LAT_MAX        16'hffff
`endif

// file: llq_pkg.sv
// Types shared by the load qualifier modules
package llq_pkg;
  // Where a tagged load's data came from
  typedef enum logic [3:0] {
    SRC_UNKNOWN_MISS, SRC_L1, SRC_PENDING, SRC_L2,
    SRC_L3_NOSNOOP, SRC_PEER_CLEAN, SRC_PEER_MOD, SRC_LAST_LEVEL_PEER_MOD,
    SRC_FWD_LOCAL, SRC_FWD_REMOTE, SRC_MEM_LOCAL_SH, SRC_MEM_REMOTE_SH,
    SRC_MEM_LOCAL_EX, SRC_MEM_REMOTE_EX, SRC_IO, SRC_UNCACHEABLE
  } llq_src_t;
  // Request kinds sent to the uncore
  typedef enum logic [3:0] {
    REQ_DEMAND_DATA, REQ_DEMAND_OWN, REQ_DEMAND_CODE, REQ_WRITEBACK,
    REQ_PF_DATA, REQ_PF_OWN, REQ_PF_CODE, REQ_OTHER
  } llq_req_t;
  // Uncore response kinds
  typedef enum logic [3:0] {
    RSP_L3_NOSNOOP, RSP_PEER_CLEAN, RSP_PEER_MOD, RSP_FWD_LOCAL,
    RSP_FWD_REMOTE, RSP_MEM_REMOTE, RSP_MEM_LOCAL, RSP_IO_HUB
  } llq_rsp_t;
endpackage : llq_pkg

// file: llq_oc_if.sv
// Carrier between the qualifier and its off-core matcher
`timescale 1ns/1ps
`default_nettype none
interface llq_oc_if;
  logic [15:0]       cfg;   // Off-core config register
  logic              valid; // Transaction present
  llq_pkg::llq_req_t req;   // Request kind
  llq_pkg::llq_rsp_t rsp;   // Response kind
  logic              hit;   // Both selections match
  modport owner (output cfg, output valid, output req, output rsp, input hit);
  modport matcher (input cfg, input valid, input req, input rsp, output hit);
endinterface : llq_oc_if
`default_nettype wire

// file: llq_oc_match.sv
// Off-core request and response selection matcher
`timescale 1ns/1ps
`default_nettype none
`include "llq_params.svh"
module llq_oc_match (
  llq_oc_if.matcher oc
);
  logic [7:0] req_onehot; // Request kind as a select bit
  logic [7:0] rsp_onehot; // Response kind as a select bit

  // Request kinds map to bits 7:0
  always_comb begin
    req_onehot = 8'h00;
    unique case (oc.req)
      llq_pkg::REQ_DEMAND_DATA: req_onehot = 8'h01;
      llq_pkg::REQ_DEMAND_OWN:  req_onehot = 8'h02;
      llq_pkg::REQ_DEMAND_CODE: req_onehot = 8'h04;
      llq_pkg::REQ_WRITEBACK:   req_onehot = 8'h08;
      llq_pkg::REQ_PF_DATA:     req_onehot = 8'h10;
      llq_pkg::REQ_PF_OWN:      req_onehot = 8'h20;
      llq_pkg::REQ_PF_CODE:     req_onehot = 8'h40;
      llq_pkg::REQ_OTHER:       req_onehot = 8'h80;
      default:                  req_onehot = 8'h00;
    endcase
  end

  // Response kinds map to bits 15:8; remote forward has no bit
  always_comb begin
    rsp_onehot = 8'h00;
    unique case (oc.rsp)
      llq_pkg::RSP_L3_NOSNOOP: rsp_onehot = 8'h01;
      llq_pkg::RSP_PEER_CLEAN: rsp_onehot = 8'h02;
      llq_pkg::RSP_PEER_MOD:   rsp_onehot = 8'h04;
      llq_pkg::RSP_FWD_LOCAL:  rsp_onehot = 8'h10;
      llq_pkg::RSP_FWD_REMOTE: rsp_onehot = 8'h00;
      llq_pkg::RSP_MEM_REMOTE: rsp_onehot = 8'h20;
      llq_pkg::RSP_MEM_LOCAL:  rsp_onehot = 8'h40;
      llq_pkg::RSP_IO_HUB:     rsp_onehot = 8'h80;
      default:                 rsp_onehot = 8'h00;
    endcase
  end

  // Both halves must find a set bit
  assign oc.hit = oc.valid
                & (|(req_onehot & oc.cfg[`LLQ_OC_REQ_LSB +: 8]))
                & (|(rsp_onehot & oc.cfg[`LLQ_OC_RSP_LSB +: 8]));
endmodule : llq_oc_match
`default_nettype wire

// file: llq_qualifier.sv
// Load-latency filter and off-core response qualifier, top level
//
// Contract
// - Codes 00H..03H: unknown miss, L1, pending, L2
// - Codes 04H..06H: no snoop, clean, modified peer
// - Code 07H only on enabled variant
// - 08H local forward; remote excluded; 09H reserved
// - 0AH..0DH memory, local/remote, shared/exclusive
// - 0EH input/output, 0FH uncacheable
// - Count only latency strictly above threshold
// - One config register at 1A6H, umask 01H
// - Bits 7:0 request, 15:8 response
// - Bits 0..2 demand data, ownership, code
// - Bit 3 writeback; 4..6 second-level prefetch
// - Bit 7 selects all remaining transactions
// - Bits 8..10 no-snoop, clean, modified hits
// - Bit 11 reserved; 12 local forward
// - Bits 13..15 remote, local memory, io hub
// - Latency counts dispatch to global observation
`timescale 1ns/1ps
`default_nettype none
`include "llq_params.svh"
module llq_qualifier #(
  parameter bit LAST_PEER_MOD_EN = 1'b0 // Variant supports code 07H
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              msr_valid,
  input  wire logic              msr_write,
  input  wire logic [31:0]       msr_addr,
  input  wire logic [63:0]       msr_wdata,
  output logic                   msr_ack,
  output logic                   msr_err,
  output logic [63:0]            msr_rdata,
  input  wire logic              ld_dispatch,
  input  wire logic              ld_go,
  input  wire llq_pkg::llq_src_t ld_src,
  output logic                   lat_above,
  output logic                   sample_valid,
  output logic [15:0]            sample_latency,
  output logic [3:0]             sample_source,
  input  wire logic [15:0]       evt_sel,
  input  wire logic              oc_valid,
  input  wire llq_pkg::llq_req_t oc_req,
  input  wire llq_pkg::llq_rsp_t oc_rsp,
  output logic                   oc_count
);
  logic [15:0] thresh_ff;   // Latency threshold in core cycles
  logic [15:0] oc_cfg_ff;   // Off-core selection bits
  logic [15:0] lat_ff;      // Running latency of the tagged load
  logic        busy_ff;     // A tagged load is in flight
  logic [15:0] nxt_lat;     // Latency seen at global observation
  logic [3:0]  nxt_code;    // Encoded data source
  logic        hit_thr;     // Load beats the threshold
  logic        sel_oc;      // Event select asks for off-core counting
  logic        acc_thr;     // Access targets the threshold
  logic        acc_oc;      // Access targets the off-core config

  llq_oc_if oc_bus ();

  // Address decode
  assign acc_thr = msr_valid & (msr_addr == `LLQ_ADDR_THRESH);
  assign acc_oc  = msr_valid & (msr_addr == `LLQ_ADDR_OC_CFG);

  // Threshold register; software keeps it at 3 or more
  always_ff @(posedge clk) begin
    if (rst) begin
      thresh_ff <= `LLQ_THR_RST;
    end else if (acc_thr & msr_write) begin
      thresh_ff <= msr_wdata[`LLQ_THR_MSB:0];
    end
  end

  // Off-core config; reserved bit 11 never stores
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_cfg_ff <= `LLQ_OC_RST;
    end else if (acc_oc & msr_write) begin
      oc_cfg_ff <= msr_wdata[15:0] & `LLQ_OC_WMASK;
    end
  end

  // Register reads, one-cycle answer; unmapped flags an error
  always_ff @(posedge clk) begin
    if (rst) begin
      msr_ack   <= 1'b0;
      msr_err   <= 1'b0;
      msr_rdata <= 64'h0;
    end else begin
      msr_ack <= msr_valid;
      msr_err <= msr_valid & ~acc_thr & ~acc_oc;
      if (acc_thr & ~msr_write) begin
        msr_rdata <= {48'h0, thresh_ff};
      end else if (acc_oc & ~msr_write) begin
        msr_rdata <= {48'h0, oc_cfg_ff};
      end else if (msr_valid) begin
        msr_rdata <= 64'h0;
      end
    end
  end

  // Every access is answered one cycle later, unmapped ones as errors
  a_ack_follows: assert property (@(posedge clk) disable iff (rst)
    msr_valid |=> msr_ack)
    else $error("register access not answered");
  a_err_unmapped: assert property (@(posedge clk) disable iff (rst)
    (msr_valid && !acc_thr && !acc_oc) |=> msr_err && msr_rdata == 64'h0)
    else $error("unmapped access not flagged");
  a_thr_write: assert property (@(posedge clk) disable iff (rst)
    (acc_thr && msr_write) |=> thresh_ff == $past(msr_wdata[15:0]))
    else $error("threshold write lost");

  // Latency seen this cycle; one at the cycle after dispatch
  assign nxt_lat = lat_ff;
  assign hit_thr = ld_go & busy_ff & (nxt_lat > thresh_ff);

  // Dispatch-to-observation counter, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      lat_ff  <= 16'h0;
    end else if (ld_dispatch) begin
      busy_ff <= 1'b1;
      lat_ff  <= 16'h1;
    end else if (ld_go) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && lat_ff != `LLQ_LAT_MAX) begin
      lat_ff <= lat_ff + 16'h1;
    end
  end

  // Each idle cycle in flight adds one; saturation keeps a stuck load from wrapping
  a_lat_step: assert property (@(posedge clk) disable iff (rst)
    (busy_ff && !ld_dispatch && !ld_go && lat_ff != 16'hffff)
      |=> lat_ff == $past(lat_ff) + 16'h1)
    else $error("latency step wrong");
  a_below_ignored: assert property (@(posedge clk) disable iff (rst)
    (ld_go && busy_ff && lat_ff <= thresh_ff) |=> !lat_above && !sample_valid)
    else $error("load at threshold counted");

  // Data-source encoding
  always_comb begin
    nxt_code = `LLQ_DS_UNK_MISS;
    unique case (ld_src)
      llq_pkg::SRC_UNKNOWN_MISS:  nxt_code = `LLQ_DS_UNK_MISS;
      llq_pkg::SRC_L1:            nxt_code = `LLQ_DS_L1;
      llq_pkg::SRC_PENDING:       nxt_code = `LLQ_DS_PENDING;
      llq_pkg::SRC_L2:            nxt_code = `LLQ_DS_L2;
      llq_pkg::SRC_L3_NOSNOOP:    nxt_code = `LLQ_DS_L3_NOSNP;
      llq_pkg::SRC_PEER_CLEAN:    nxt_code = `LLQ_DS_PEER_CLEAN;
      llq_pkg::SRC_PEER_MOD:      nxt_code = `LLQ_DS_PEER_MOD;
      // Without the variant, 07H stays unused; fall back to 06H
      llq_pkg::SRC_LAST_LEVEL_PEER_MOD: nxt_code = LAST_PEER_MOD_EN ?
                                    `LLQ_DS_LAST_MODHIT : `LLQ_DS_PEER_MOD;
      llq_pkg::SRC_FWD_LOCAL:     nxt_code = `LLQ_DS_FWD_LOCAL;
      // Remote-homed forward is not 08H; 09H is never produced
      llq_pkg::SRC_FWD_REMOTE:    nxt_code = `LLQ_DS_UNK_MISS;
      llq_pkg::SRC_MEM_LOCAL_SH:  nxt_code = `LLQ_DS_LMEM_SH;
      llq_pkg::SRC_MEM_REMOTE_SH: nxt_code = `LLQ_DS_RMEM_SH;
      llq_pkg::SRC_MEM_LOCAL_EX:  nxt_code = `LLQ_DS_LMEM_EX;
      llq_pkg::SRC_MEM_REMOTE_EX: nxt_code = `LLQ_DS_RMEM_EX;
      llq_pkg::SRC_IO:            nxt_code = `LLQ_DS_IO;
      llq_pkg::SRC_UNCACHEABLE:   nxt_code = `LLQ_DS_UC;
    endcase
  end

  // Sample record fields; only loads above threshold update them
  always_ff @(posedge clk) begin
    if (rst) begin
      lat_above      <= 1'b0;
      sample_valid   <= 1'b0;
      sample_latency <= 16'h0;
      sample_source  <= 4'h0;
    end else begin
      lat_above    <= hit_thr;
      sample_valid <= hit_thr;
      if (hit_thr) begin
        sample_latency <= nxt_lat;
        sample_source  <= nxt_code;
      end
    end
  end

  // Fields only move for a counted load; one check per source kind
  // A record that moved between hits would pair the wrong latency and source
  a_sample_hold: assert property (@(posedge clk) disable iff (rst)
    !hit_thr |=> $stable(sample_latency) && $stable(sample_source))
    else $error("sample fields moved");
  a_src_unknown: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_UNKNOWN_MISS) |=> sample_source == 4'h0)
    else $error("unknown miss code wrong");
  a_src_pending: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_PENDING) |=> sample_source == 4'h2)
    else $error("pending miss code wrong");
  a_src_l2: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_L2) |=> sample_source == 4'h3)
    else $error("second level code wrong");
  a_src_nosnoop: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_L3_NOSNOOP) |=> sample_source == 4'h4)
    else $error("no snoop hit code wrong");
  a_src_peer_clean: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_PEER_CLEAN) |=> sample_source == 4'h5)
    else $error("clean peer code wrong");
  a_src_peer_mod: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_PEER_MOD) |=> sample_source == 4'h6)
    else $error("modified peer code wrong");
  a_src_fwd_local: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_FWD_LOCAL) |=> sample_source == 4'h8)
    else $error("local forward code wrong");
  a_src_fwd_remote: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_FWD_REMOTE) |=> sample_source == 4'h0)
    else $error("remote forward code wrong");
  a_src_lmem_sh: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_MEM_LOCAL_SH) |=> sample_source == 4'ha)
    else $error("local shared code wrong");
  a_src_rmem_sh: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_MEM_REMOTE_SH) |=> sample_source == 4'hb)
    else $error("remote shared code wrong");
  a_src_lmem_ex: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_MEM_LOCAL_EX) |=> sample_source == 4'hc)
    else $error("local exclusive code wrong");
  a_src_io: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_IO) |=> sample_source == 4'he)
    else $error("input output code wrong");

  // Off-core event selected by code and unit mask
  assign sel_oc = (evt_sel[7:0] == `LLQ_OC_EVT_CODE)
                & (evt_sel[15:8] == `LLQ_OC_UMASK);

  // Hand the transaction to the matcher
  assign oc_bus.cfg   = oc_cfg_ff;
  assign oc_bus.valid = oc_valid & sel_oc;
  assign oc_bus.req   = oc_req;
  assign oc_bus.rsp   = oc_rsp;

  llq_oc_match u_match (
    .oc (oc_bus.matcher)
  );

  // Registered count pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_count <= 1'b0;
    end else begin
      oc_count <= oc_bus.hit;
    end
  end

  // Remote-homed forwards have no select bit and never count
  // With every defined bit set, any other selected transaction must count
  a_oc_fwd_remote: assert property (@(posedge clk) disable iff (rst)
    (oc_valid && oc_rsp == llq_pkg::RSP_FWD_REMOTE) |=> !oc_count)
    else $error("remote forward counted");
  a_oc_full_cfg: assert property (@(posedge clk) disable iff (rst)
    (oc_valid && sel_oc && oc_cfg_ff == 16'hf7ff && oc_rsp != llq_pkg::RSP_FWD_REMOTE)
      |=> oc_count)
    else $error("selected transaction not counted");

  // Checks
  a_above_thresh: assert property (@(posedge clk) disable iff (rst)
    lat_above |-> $past(lat_ff) > $past(thresh_ff))
    else $error("latency not above threshold");
  a_go_counted: assert property (@(posedge clk) disable iff (rst)
    (ld_go && busy_ff && lat_ff > thresh_ff) |=> lat_above && sample_valid)
    else $error("qualifying load not counted");
  a_lat_span: assert property (@(posedge clk) disable iff (rst)
    (ld_dispatch ##1 (!ld_dispatch && !ld_go)[*3] ##1 ld_go) |-> lat_ff == 16'h4)
    else $error("latency count wrong");
  a_src_l1: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_L1) |=> sample_source == 4'h1)
    else $error("L1 source code wrong");
  a_src_variant: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_LAST_LEVEL_PEER_MOD)
      |=> sample_source == (LAST_PEER_MOD_EN ? 4'h7 : 4'h6))
    else $error("code 07H misused");
  a_src_fwd: assert property (@(posedge clk) disable iff (rst)
    sample_valid |-> sample_source != 4'h9)
    else $error("reserved 09H reported");
  a_src_mem: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_MEM_REMOTE_EX) |=> sample_source == 4'hd)
    else $error("remote exclusive code wrong");
  a_src_uc: assert property (@(posedge clk) disable iff (rst)
    (hit_thr && ld_src == llq_pkg::SRC_UNCACHEABLE) |=> sample_source == 4'hf)
    else $error("uncacheable code wrong");
  a_rsvd_bit: assert property (@(posedge clk) disable iff (rst)
    oc_cfg_ff[`LLQ_OC_RSVD_BIT] == 1'b0)
    else $error("reserved response bit stored");
  a_cfg_readback: assert property (@(posedge clk) disable iff (rst)
    (acc_oc && msr_write) ##1 (msr_valid && !msr_write && msr_addr == 32'h1a6)
      |=> msr_rdata[15:0] == ($past(msr_wdata[15:0], 2) & 16'hf7ff))
    else $error("config readback wrong");
  a_oc_match: assert property (@(posedge clk) disable iff (rst)
    oc_count |-> $past(oc_valid && sel_oc
      && (oc_cfg_ff[7:0] != 8'h0) && (oc_cfg_ff[15:8] != 8'h0)))
    else $error("off-core count without selection");
  a_oc_evtsel: assert property (@(posedge clk) disable iff (rst)
    (evt_sel[15:8] != 8'h01) |=> !oc_count)
    else $error("off-core counted with wrong mask");
endmodule : llq_qualifier
`default_nettype wire

// file: llq_far_model.sv
// Far-side load pipeline model: dispatches and observes tagged loads
`timescale 1ns/1ps
`default_nettype none
module llq_far_model (
  input  wire logic              clk,
  input  wire logic              ld_start,  // Bench asks for one load
  input  wire logic [15:0]       ld_lat,    // Edges from dispatch to observation
  input  wire llq_pkg::llq_src_t ld_src_in, // Source given at observation
  output logic                   ld_dispatch,
  output logic                   ld_go,
  output llq_pkg::llq_src_t      ld_src,
  output logic                   ld_busy
);
  logic [15:0] left_ff; // Edges still to wait
  // Known values before the first edge
  initial begin
    ld_dispatch = 1'b0;
    ld_go = 1'b0;
    ld_src = llq_pkg::SRC_L1;
    ld_busy = 1'b0;
    left_ff = 16'h0000;
  end
  // Dispatch, then observation ld_lat edges later; a latency of 0 is never asked
  always @(posedge clk) begin
    ld_dispatch <= ld_start && !ld_busy;
    ld_go <= ld_busy && left_ff == 16'h0001;
    // Source is garbage outside observation, so a stale value cannot pass
    ld_src <= llq_pkg::llq_src_t'(~ld_src);
    if (ld_start && !ld_busy) begin
      ld_busy <= 1'b1;
      left_ff <= ld_lat;
    end else if (ld_busy) begin
      left_ff <= left_ff - 16'h0001;
      if (left_ff == 16'h0001) begin
        ld_busy <= 1'b0;
        ld_src <= ld_src_in;
      end
    end
  end
endmodule : llq_far_model
`default_nettype wire

// file: llq_qualifier_bench.sv
// Self-checking bench of the load qualifier
`timescale 1ns/1ps
`default_nettype none
module llq_qualifier_bench;
  logic clk = 1'b0, rst = 1'b1, msr_valid = 1'b0, msr_write = 1'b0, msr_ack, msr_err;
  logic [31:0] msr_addr = 32'h0;
  logic [63:0] msr_wdata = 64'h0, msr_rdata;
  logic ld_dispatch, ld_go, lat_above, sample_valid, oc_count, ld_start = 1'b0, ld_busy;
  llq_pkg::llq_src_t ld_src, ld_src_in = llq_pkg::SRC_L1;
  logic [15:0] sample_latency, ld_lat = 16'h4, evt_sel = 16'h0, cfg, thr;
  logic [3:0] sample_source;
  logic oc_valid = 1'b0;
  llq_pkg::llq_req_t oc_req = llq_pkg::REQ_OTHER;
  llq_pkg::llq_rsp_t oc_rsp = llq_pkg::RSP_IO_HUB;
  logic [65:0] reg_q[$], n; // Register notes: {data checked, err, data}
  logic [20:0] smp_q[$];   // Sample notes: {pulse, latency, source}
  logic oc_q[$];           // One note per expected count pulse
  int error_cnt = 0, comparisons = 0, cyc = 0;
  int rsp_bit[8] = '{8, 9, 10, 12, 11, 13, 14, 15}; // Bit 11 is reserved, reads 0
  llq_qualifier i_dut (.clk(clk), .rst(rst), .msr_valid(msr_valid), .msr_write(msr_write),
    .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_ack(msr_ack), .msr_err(msr_err),
    .msr_rdata(msr_rdata), .ld_dispatch(ld_dispatch), .ld_go(ld_go), .ld_src(ld_src),
    .lat_above(lat_above), .sample_valid(sample_valid), .sample_latency(sample_latency),
    .sample_source(sample_source), .evt_sel(evt_sel), .oc_valid(oc_valid),
    .oc_req(oc_req), .oc_rsp(oc_rsp), .oc_count(oc_count));
  llq_far_model i_far (.clk(clk), .ld_start(ld_start), .ld_lat(ld_lat),
    .ld_src_in(ld_src_in), .ld_dispatch(ld_dispatch), .ld_go(ld_go), .ld_src(ld_src),
    .ld_busy(ld_busy));
  // 25 MHz clock
  always #20 clk = ~clk;
  // Compare and count
  task check(input logic [65:0] seen, input logic [65:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Output watcher: outputs are registered, so the falling edge sees them settled
  always @(negedge clk) if (!rst) begin
    if (msr_ack === 1'b1) begin
      if (reg_q.size() == 0) check(0, 1, "stray ack");
      else begin
        n = reg_q.pop_front();
        check({n[65], msr_err, n[65] ? msr_rdata : 64'h0}, n, "register");
      end
    end
    if (sample_valid === 1'b1) begin
      if (smp_q.size() == 0) check(0, 1, "stray sample");
      else check({lat_above, sample_latency, sample_source}, smp_q.pop_front(), "sample");
    end
    if (oc_count === 1'b1) begin
      if (oc_q.size() == 0) check(0, 1, "stray count");
      else check(1, oc_q.pop_front(), "count");
    end
  end
  // One register access; the answer comes one cycle later
  task reg_op(input logic wr, input logic [31:0] a, input logic [63:0] d, input logic [65:0] e);
    @(negedge clk);
    msr_valid = 1'b1;
    msr_write = wr;
    msr_addr = a;
    msr_wdata = d;
    reg_q.push_back(e);
    @(negedge clk);
    msr_valid = 1'b0;
    msr_addr = ~a;
    msr_wdata = ~d;
  endtask : reg_op
  // Config write then read on back-to-back cycles; the read sees the new value
  task reg_wr_rd(input logic [15:0] c);
    @(negedge clk);
    msr_valid = 1'b1;
    msr_write = 1'b1;
    msr_addr = 32'h1a6;
    msr_wdata = {48'h0, c};
    reg_q.push_back({2'b00, 64'h0});
    @(negedge clk);
    msr_write = 1'b0;
    msr_wdata = ~{48'h0, c};
    reg_q.push_back({2'b10, 48'h0, c & 16'hf7ff});
    @(negedge clk);
    msr_valid = 1'b0;
    msr_addr = 32'h1a5;
  endtask : reg_wr_rd
  // One tagged load through the far-side model
  task load(input logic [15:0] lat, input llq_pkg::llq_src_t s);
    logic [3:0] code;
    code = s;
    if (s == llq_pkg::SRC_LAST_LEVEL_PEER_MOD) code = 4'h6;
    if (s == llq_pkg::SRC_FWD_REMOTE) code = 4'h0;
    @(negedge clk);
    ld_start = 1'b1;
    ld_lat = lat;
    ld_src_in = s;
    if (lat > thr) smp_q.push_back({1'b1, lat, code});
    @(negedge clk);
    ld_start = 1'b0;
    while (ld_busy) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask : load
  // One off-core transaction; request and response lines scrambled when idle
  task oc_tx(input llq_pkg::llq_req_t r, input llq_pkg::llq_rsp_t p);
    @(negedge clk);
    oc_valid = 1'b1;
    oc_req = r;
    oc_rsp = p;
    if (evt_sel == 16'h01b7 && cfg[r] && cfg[rsp_bit[p]]) oc_q.push_back(1'b1);
    @(negedge clk);
    oc_valid = 1'b0;
    oc_req = llq_pkg::llq_req_t'(~r);
    oc_rsp = llq_pkg::llq_rsp_t'(~p);
  endtask : oc_tx
  // Every note must have been met by now
  task done(input string name);
    repeat (4) @(negedge clk);
    check(66'(reg_q.size() + smp_q.size() + oc_q.size()), 0, "missing result");
    $display("test %s done", name);
  endtask : done
  // Main sequence
  initial begin
    void'($urandom(32'h855f));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    thr = 16'h0003;
    // Reset values, read-back mask, unmapped places
    reg_op(0, 32'h3f6, 0, {2'b10, 64'h3});
    reg_op(0, 32'h1a6, 0, {2'b10, 64'h0});
    reg_op(1, 32'h1a6, '1, {2'b00, 64'h0});
    reg_op(0, 32'h1a6, 0, {2'b10, 64'hf7ff});
    reg_op(1, 32'h1a7, 64'h0, {2'b01, 64'h0});
    reg_op(0, 32'h1a5, 0, {2'b11, 64'h0});
    reg_op(0, 32'h1a6, 0, {2'b10, 64'hf7ff});
    done("registers");
    // Every source code at threshold 3; latency 3 is ignored
    for (int s = 0; s < 16; s++) load(16'(4 + s), llq_pkg::llq_src_t'(s));
    load(16'h3, llq_pkg::SRC_L2);
    done("sources");
    // Random threshold never below 3, boundary then random loads
    thr = 16'($urandom_range(30, 3));
    reg_op(1, 32'h3f6, {48'habcd_0000_0000, thr}, {2'b00, 64'h0});
    reg_op(0, 32'h3f6, 0, {2'b10, 48'h0, thr});
    load(thr, llq_pkg::SRC_L1);
    load(thr + 16'h1, llq_pkg::SRC_IO);
    repeat (8) load(16'($urandom_range(40, 2)), llq_pkg::llq_src_t'($urandom_range(15, 0)));
    done("threshold");
    // Off-core selection: all-ones then random configs, every request and response kind
    evt_sel = 16'h01b7;
    for (int k = 0; k < 5; k++) begin
      cfg = (k == 0) ? 16'hffff : 16'($urandom());
      reg_wr_rd(cfg);
      cfg = cfg & 16'hf7ff;
      for (int r = 0; r < 8; r++)
        for (int p = 0; p < 8; p++) oc_tx(llq_pkg::llq_req_t'(r), llq_pkg::llq_rsp_t'(p));
    end
    done("offcore");
    // Wrong event code or unit mask never counts, even with every bit selected
    reg_wr_rd(16'hffff);
    evt_sel = 16'h02b7;
    oc_tx(llq_pkg::REQ_OTHER, llq_pkg::RSP_IO_HUB);
    evt_sel = 16'h01b6;
    oc_tx(llq_pkg::REQ_DEMAND_DATA, llq_pkg::RSP_L3_NOSNOOP);
    done("event select");
    complete_run();
  end
endmodule : llq_qualifier_bench
`default_nettype wire
